//--- pkg/scalu_pkg.sv
`default_nettype none
package scalu_pkg;

  // ------------------------------------------------------------
  // Instruction word layout
  // ------------------------------------------------------------
  localparam int OPC_HI = 31;
  localparam int OPC_LO = 26;
  localparam int ZW_BIT = 25;
  localparam int CW_BIT = 24;
  localparam int RW_BIT = 23;
  localparam int IMM_BIT = 22;
  localparam int CON_HI = 21;
  localparam int CON_LO = 18;
  localparam int DST_HI = 17;
  localparam int DST_LO = 9;
  localparam int SRC_HI = 8;
  localparam int SRC_LO = 0;
  localparam int FLD_W = 9;

  localparam logic [5:0] OPC_SIGNED_COMPARE = 6'h30;
  localparam logic [5:0] OPC_SIGNED_COMPARE_EXT = 6'h31;
  localparam logic [5:0] OPC_COMPARE_SUBTRACT = 6'h38;
  localparam logic [3:0] CON_ALWAYS = 4'hF;
  // Default effect bits Z,C,R (immediate bit comes from the word)
  localparam logic [2:0] DFLT_ZCR_COMPARE = 3'h0;
  localparam logic [2:0] DFLT_ZCR_SUBTRACT = 3'h1;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int EXEC_CYCLES = 4;
  localparam logic [2:0] EXEC_CNT_LAST = 3'(EXEC_CYCLES - 3);

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_INSTR = 12'h000;
  localparam logic [11:0] OFF_ISSUE_DFLT = 12'h004;
  localparam logic [11:0] OFF_FLAGS = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00C;
  localparam logic [11:0] OFF_RESULT = 12'h010;
  localparam logic [11:0] OFF_RETIRED = 12'h014;
  localparam logic [11:0] OFF_RF_BASE = 12'h100;
  localparam int FLAG_Z_BIT = 0;
  localparam int FLAG_C_BIT = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_BAD = 2;
  localparam int STAT_REFUSED = 3;
  localparam int STAT_WROTE = 4;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic RST_FLAG = 1'b0;

  typedef enum logic [2:0] {
    SCALU_OP_NONE = 3'h0,
    SCALU_OP_SC = 3'h1,
    SCALU_OP_SCX = 3'h2,
    SCALU_OP_CSUB = 3'h4
  } scalu_op_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_LOAD = 4'h2,
    ST_EXEC = 4'h4,
    ST_COMMIT = 4'h8
  } scalu_state_e;

  function automatic scalu_op_e op_of(input logic [5:0] opc);
    case (opc)
      OPC_SIGNED_COMPARE: op_of = SCALU_OP_SC;
      OPC_SIGNED_COMPARE_EXT: op_of = SCALU_OP_SCX;
      OPC_COMPARE_SUBTRACT: op_of = SCALU_OP_CSUB;
      default: op_of = SCALU_OP_NONE;
    endcase
  endfunction

  function automatic logic [2:0] dflt_zcr(input logic [5:0] opc);
    dflt_zcr = (opc == OPC_COMPARE_SUBTRACT) ? DFLT_ZCR_SUBTRACT
                                             : DFLT_ZCR_COMPARE;
  endfunction

endpackage
`default_nettype wire

//--- rtl/scalu_dec.sv
`timescale 1ns/10ps
`default_nettype none
module scalu_dec
  import scalu_pkg::*;
#(
  parameter int IW = 4
) (
  // Instruction
  input wire logic [31:0] instr,
  // Decoded fields
  output scalu_op_e op,
  output logic legal,
  output logic zw,
  output logic cw,
  output logic rw,
  output logic imm,
  output logic [IW-1:0] d_idx,
  output logic [FLD_W-1:0] s_field
);

  function automatic logic fits(input logic [FLD_W-1:0] f);
    fits = (f >> IW) == '0;
  endfunction

  wire [FLD_W-1:0] d_field = instr[DST_HI:DST_LO];
  wire src_ok = instr[IMM_BIT] || fits(instr[SRC_HI:SRC_LO]);

  assign op = op_of(instr[OPC_HI:OPC_LO]);
  assign zw = instr[ZW_BIT];
  assign cw = instr[CW_BIT];
  assign rw = instr[RW_BIT];
  assign imm = instr[IMM_BIT];
  assign d_idx = d_field[IW-1:0];
  assign s_field = instr[SRC_HI:SRC_LO];
  // Unknown opcode, non-always condition or missing register: illegal, flagged bad when issued while idle
  assign legal = (op != SCALU_OP_NONE) &&
                 (instr[CON_HI:CON_LO] == CON_ALWAYS) &&
                 fits(d_field) && src_ok;

endmodule
`default_nettype wire

//--- rtl/scalu_calc.sv
`timescale 1ns/10ps
`default_nettype none
module scalu_calc
  import scalu_pkg::*;
#(
  parameter int W = 32
) (
  // Operation and operands
  input wire scalu_op_e op,
  input wire logic [W-1:0] dst,
  input wire logic [W-1:0] src,
  input wire logic z_in,
  input wire logic c_in,
  // Results
  output logic [W-1:0] res,
  output logic z_out,
  output logic c_out,
  output logic res_ok
);

  wire ci = (op == SCALU_OP_SCX) && c_in;
  wire [W+1:0] dx = {{2{dst[W-1]}}, dst};
  wire [W+1:0] sx = {{2{src[W-1]}}, src} + {{(W+1){1'b0}}, ci};
  wire lt_s = $signed(dx) < $signed(sx);
  wire eq_s = dx == sx;
  wire ge_u = dst >= src;
  wire [W-1:0] diff = dst - src - {{(W-1){1'b0}}, ci};
  wire is_csub = op == SCALU_OP_CSUB;

  // Difference may wrap; SC and SCX flags follow the true signed order, CSUB carry the unsigned order
  assign res = (is_csub && !ge_u) ? dst : diff;
  assign z_out = (op == SCALU_OP_SCX) ? (z_in && eq_s) : eq_s;
  assign c_out = is_csub ? ge_u : lt_s;
  assign res_ok = !is_csub || ge_u;

endmodule
`default_nettype wire

//--- rtl/scalu_top.sv
`timescale 1ns/10ps
`default_nettype none
module scalu_top
  import scalu_pkg::*;
#(
  parameter int W = 32,
  parameter int RF_DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  // Status
  output logic busy,
  output logic done,
  output logic z_flag,
  output logic c_flag
);

  localparam int IW = $clog2(RF_DEPTH);
  localparam logic [ADDR_W-3:0] RF_DEPTH_V = (ADDR_W-2)'(RF_DEPTH);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  scalu_state_e state_q;
  scalu_state_e state_d;
  scalu_op_e op_q;
  scalu_op_e dec_op;
  logic [2:0] cnt_q;
  logic [31:0] instr_q;
  logic zw_q;
  logic cw_q;
  logic rw_q;
  logic imm_q;
  logic [IW-1:0] d_idx_q;
  logic [FLD_W-1:0] s_field_q;
  logic [W-1:0] dst_q;
  logic [W-1:0] src_q;
  logic [W-1:0] res_q;
  logic z_new_q;
  logic c_new_q;
  logic ok_q;
  logic z_q;
  logic c_q;
  logic done_q;
  logic done_st_q;
  logic bad_q;
  logic refused_q;
  logic wrote_q;
  logic [31:0] retired_q;
  logic [31:0] rdata_q;
  logic [W-1:0] rf_q [RF_DEPTH];

  logic dec_legal;
  logic dec_zw;
  logic dec_cw;
  logic dec_rw;
  logic dec_imm;
  logic [IW-1:0] dec_d_idx;
  logic [FLD_W-1:0] dec_s_field;
  logic [W-1:0] calc_res;
  logic calc_z;
  logic calc_c;
  logic calc_ok;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  wire hit_instr = addr == OFF_INSTR;
  wire hit_dflt = addr == OFF_ISSUE_DFLT;
  wire hit_flags = addr == OFF_FLAGS;
  wire hit_status = addr == OFF_STATUS;
  wire hit_result = addr == OFF_RESULT;
  wire hit_retired = addr == OFF_RETIRED;
  wire [ADDR_W-1:0] rf_off = addr - OFF_RF_BASE;
  wire rf_hit = (addr >= OFF_RF_BASE) && (rf_off[1:0] == 2'h0) &&
                (rf_off[ADDR_W-1:2] < RF_DEPTH_V);
  wire [IW-1:0] rf_idx = rf_off[IW+1:2];

  // ------------------------------------------------------------
  // Issue
  // ------------------------------------------------------------
  wire idle = state_q == ST_IDLE;
  wire issue_wr = wr_en && (hit_instr || hit_dflt);
  wire [2:0] zcr_dflt = dflt_zcr(wdata[OPC_HI:OPC_LO]);
  // Default issue takes Z, C and R from the opcode's defaults
  wire [31:0] issue_word = hit_dflt ?
    {wdata[OPC_HI:OPC_LO], zcr_dflt, wdata[IMM_BIT:0]} : wdata;
  wire accept = issue_wr && idle && dec_legal;
  wire bad_set = issue_wr && idle && !dec_legal;
  wire refused_set = issue_wr && !idle;

  scalu_dec #(
    .IW(IW)
  ) u_dec (
    .instr(issue_word),
    .op(dec_op),
    .legal(dec_legal),
    .zw(dec_zw),
    .cw(dec_cw),
    .rw(dec_rw),
    .imm(dec_imm),
    .d_idx(dec_d_idx),
    .s_field(dec_s_field)
  );

  // ------------------------------------------------------------
  // Operand selection
  // ------------------------------------------------------------
  wire [IW-1:0] s_idx = s_field_q[IW-1:0];
  wire [W-1:0] imm_ext = {{(W-FLD_W){1'b0}}, s_field_q};
  wire [W-1:0] src_sel = imm_q ? imm_ext : rf_q[s_idx];
  wire exec_last = (state_q == ST_EXEC) && (cnt_q == EXEC_CNT_LAST);

  // ------------------------------------------------------------
  // Arithmetic
  // ------------------------------------------------------------
  scalu_calc #(
    .W(W)
  ) u_calc (
    .op(op_q),
    .dst(dst_q),
    .src(src_q),
    .z_in(z_q),
    .c_in(c_q),
    .res(calc_res),
    .z_out(calc_z),
    .c_out(calc_c),
    .res_ok(calc_ok)
  );

  // ------------------------------------------------------------
  // Commit decode
  // ------------------------------------------------------------
  wire commit = state_q == ST_COMMIT;
  wire rf_commit = commit && rw_q && ok_q;
  wire z_commit = commit && zw_q;
  wire c_commit = commit && cw_q;
  wire flags_wr = wr_en && hit_flags;
  wire status_wr = wr_en && hit_status;
  wire rf_bus_wr = wr_en && rf_hit;

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb begin
    case (state_q)
      ST_IDLE: state_d = accept ? ST_LOAD : ST_IDLE;
      ST_LOAD: state_d = ST_EXEC;
      ST_EXEC: state_d = exec_last ? ST_COMMIT : ST_EXEC;
      ST_COMMIT: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // Four busy cycles from the issue edge to the commit edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 3'h0;
    end else if (state_q == ST_EXEC) begin
      cnt_q <= cnt_q + 3'h1;
    end else begin
      cnt_q <= 3'h0;
    end
  end

  // ------------------------------------------------------------
  // Instruction latch
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      instr_q <= RST_WORD;
      op_q <= SCALU_OP_NONE;
      zw_q <= 1'b0;
      cw_q <= 1'b0;
      rw_q <= 1'b0;
      imm_q <= 1'b0;
      d_idx_q <= '0;
      s_field_q <= '0;
    end else if (accept) begin
      instr_q <= issue_word;
      op_q <= dec_op;
      zw_q <= dec_zw;
      cw_q <= dec_cw;
      rw_q <= dec_rw;
      imm_q <= dec_imm;
      d_idx_q <= dec_d_idx;
      s_field_q <= dec_s_field;
    end
  end

  // ------------------------------------------------------------
  // Operand and result latches
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dst_q <= '0;
      src_q <= '0;
    end else if (state_q == ST_LOAD) begin
      dst_q <= rf_q[d_idx_q];
      src_q <= src_sel;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      res_q <= '0;
      z_new_q <= 1'b0;
      c_new_q <= 1'b0;
      ok_q <= 1'b0;
    end else if (exec_last) begin
      res_q <= calc_res;
      z_new_q <= calc_z;
      c_new_q <= calc_c;
      ok_q <= calc_ok;
    end
  end

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  // Commit wins over a bus write to the same entry
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < RF_DEPTH; i++) begin
        rf_q[i] <= '0;
      end
    end else begin
      if (rf_bus_wr) begin
        rf_q[rf_idx] <= wdata[W-1:0];
      end
      if (rf_commit) begin
        rf_q[d_idx_q] <= res_q;
      end
    end
  end

  // ------------------------------------------------------------
  // Flags
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      z_q <= RST_FLAG;
    end else if (z_commit) begin
      z_q <= z_new_q;
    end else if (flags_wr) begin
      z_q <= wdata[FLAG_Z_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      c_q <= RST_FLAG;
    end else if (c_commit) begin
      c_q <= c_new_q;
    end else if (flags_wr) begin
      c_q <= wdata[FLAG_C_BIT];
    end
  end

  // ------------------------------------------------------------
  // Status
  // ------------------------------------------------------------
  // Sticky bits clear on write of one; a same-cycle set wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      done_st_q <= 1'b0;
      bad_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      done_st_q <= commit ||
                   (done_st_q && !(status_wr && wdata[STAT_DONE]));
      bad_q <= bad_set ||
               (bad_q && !(status_wr && wdata[STAT_BAD]));
      refused_q <= refused_set ||
                   (refused_q && !(status_wr && wdata[STAT_REFUSED]));
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      done_q <= 1'b0;
      wrote_q <= 1'b0;
      retired_q <= RST_WORD;
    end else begin
      done_q <= commit;
      if (commit) begin
        wrote_q <= rw_q && ok_q;
        retired_q <= retired_q + 32'h0000_0001;
      end
    end
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  wire [31:0] flags_word = {30'h0, c_q, z_q};
  wire [31:0] status_word = {27'h0, wrote_q, refused_q, bad_q, done_st_q,
                             !idle};
  wire [31:0] rf_word = {{(32-W){1'b0}}, rf_q[rf_idx]};
  wire [31:0] res_word = {{(32-W){1'b0}}, res_q};
  wire [31:0] rd_mux =
    hit_instr ? instr_q :
    hit_flags ? flags_word :
    hit_status ? status_word :
    hit_result ? res_word :
    hit_retired ? retired_q :
    rf_hit ? rf_word : 32'h0000_0000;

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= RST_WORD;
    end else begin
      rdata_q <= rd_en ? rd_mux : RST_WORD;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign rdata = rdata_q;
  assign busy = !idle;
  assign done = done_q;
  assign z_flag = z_q;
  assign c_flag = c_q;

endmodule
`default_nettype wire

//--- verif/scalu_top_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module scalu_monitor
  import scalu_pkg::*;
#(
  parameter int W = 32,
  parameter int RF_DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rdata,
  // Status
  input wire logic busy,
  input wire logic done,
  input wire logic z_flag,
  input wire logic c_flag
);
  // ------------------------------------------------------------
  // Issue decode
  // ------------------------------------------------------------
  wire logic [5:0] opc_w = wdata[OPC_HI:OPC_LO];
  wire logic known_w = opc_w == OPC_SIGNED_COMPARE ||
    opc_w == OPC_SIGNED_COMPARE_EXT || opc_w == OPC_COMPARE_SUBTRACT;
  wire logic legal_w = known_w && wdata[CON_HI:CON_LO] == CON_ALWAYS &&
    wdata[DST_HI:DST_LO] < RF_DEPTH &&
    (wdata[IMM_BIT] || wdata[SRC_HI:SRC_LO] < RF_DEPTH);
  wire logic issue_w = wr_en && (addr == OFF_INSTR || addr == OFF_ISSUE_DFLT);
  wire logic go_w = issue_w && legal_w && !busy;
  wire logic flag_wr_w = wr_en && addr == OFF_FLAGS;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_busy_four_cycles: assert property (
    $rose(busy) |-> busy [*4] ##1 !busy)
    else $error("busy length differs from four cycles");
  chk_issue_starts: assert property (go_w |=> busy)
    else $error("legal issue did not start");
  chk_busy_cause: assert property ($rose(busy) |-> $past(go_w))
    else $error("busy rose without a legal issue");
  chk_done_at_end: assert property ($fell(busy) |-> done)
    else $error("done missing at end of execution");
  chk_done_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
  chk_flags_hold: assert property (
    $changed({z_flag, c_flag}) |-> $past(flag_wr_w) || $fell(busy))
    else $error("flags changed without commit or write");
  chk_rdata_idle: assert property (!$past(rd_en) |-> rdata == 32'h0)
    else $error("read data not zero outside read cycle");
  chk_busy_no_done: assert property (busy |-> !done)
    else $error("done while busy");

  cover property ($rose(busy) ##4 done);
  cover property ($rose(c_flag));
  cover property (issue_w && busy);
endmodule
`default_nettype wire

//--- verif/test_signed_compare_alu.sv
`timescale 1ns/10ps
`default_nettype none
module test_signed_compare_alu;
  import scalu_pkg::*;
  logic clk, rst_b, wr_en, rd_en, busy, done, z_flag, c_flag;
  logic [ADDR_W-1:0] addr;
  logic [31:0] wdata, rdata;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  int retired_exp = 0;
  logic [31:0] td [10] = '{32'h3, 32'h3, 32'h3, 32'h80000000, 32'h7FFFFFFF,
    32'h80000000, 32'h7FFFFFFF, 32'hFFFFFFFE, 32'hFFFFFFFE, 32'hFFFFFFFE};
  logic [31:0] ts [10] = '{32'h2, 32'h3, 32'h4, 32'h7FFFFFFF, 32'h80000000,
    32'h1, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFE, 32'hFFFFFFFD};

  scalu_top #(.W(32), .RF_DEPTH(16)) uut (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .busy(busy), .done(done),
    .z_flag(z_flag), .c_flag(c_flag));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Bus tasks and checks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic wait_done(output int n);
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1 n++;
    end
  endtask

  // Runs one instruction on entry 1 with entry 2 or an immediate as source
  task automatic run(input logic [5:0] opc, input logic [2:0] zcr,
      input logic im, input logic [31:0] dv, input logic [31:0] sv,
      input logic zi, input logic ci, input logic dflt);
    logic [31:0] s, v, res;
    longint sd, ss;
    logic zo, co, ok, ze, ce;
    int n;
    s = im ? {23'h0, sv[8:0]} : sv;
    wr(OFF_RF_BASE + 12'h004, dv);
    wr(OFF_RF_BASE + 12'h008, sv);
    wr(OFF_FLAGS, {30'h0, ci, zi});
    wr(dflt ? OFF_ISSUE_DFLT : OFF_INSTR, {opc, zcr, im, CON_ALWAYS, 9'h001,
      im ? sv[8:0] : 9'h002});
    wait_done(n);
    retired_exp++;
    check(32'(n), 32'h4);
    if (dflt) zcr = (opc == OPC_COMPARE_SUBTRACT) ? 3'h1 : 3'h0;
    sd = longint'($signed(dv));
    ss = longint'($signed(s));
    ok = zcr[0];
    if (opc == OPC_SIGNED_COMPARE) begin
      zo = dv == s;
      co = sd < ss;
      res = dv - s;
    end else if (opc == OPC_SIGNED_COMPARE_EXT) begin
      ss = ss + (ci ? 64'sd1 : 64'sd0);
      zo = zi && sd == ss;
      co = sd < ss;
      res = dv - s - {31'h0, ci};
    end else begin
      zo = dv == s;
      co = dv >= s;
      res = co ? dv - s : dv;
      ok = zcr[0] && co;
    end
    ze = zcr[2] ? zo : zi;
    ce = zcr[1] ? co : ci;
    check({30'h0, c_flag, z_flag}, {30'h0, ce, ze});
    rd(OFF_RF_BASE + 12'h004, v);
    check(v, ok ? res : dv);
    rd(OFF_FLAGS, v);
    check(v, {30'h0, ce, ze});
    rd(OFF_RESULT, v);
    check(v, res);
  endtask

  task automatic print_verdict();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict();
    end
  end

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] v, r, w;
    int k;
    rst_b = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = '0;
    wdata = '0;
    void'($urandom(32'hE1B1));
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(OFF_FLAGS, v);
    check(v, 32'h0);
    rd(OFF_RF_BASE + 12'h014, v);
    check(v, 32'h0);
    rd(12'h200, v);
    check(v, 32'h0);
    for (int i = 0; i < 10; i++) begin
      run(OPC_SIGNED_COMPARE, 3'h7, 1'b0, td[i], ts[i],
        1'b0, 1'b0, 1'b0);
      run(OPC_SIGNED_COMPARE_EXT, 3'h7, 1'b0, td[i], ts[i],
        i[0], i[1], 1'b0);
      run(OPC_COMPARE_SUBTRACT, 3'h6, i[0], td[i], ts[i],
        1'b1, 1'b1, 1'b0);
    end
    run(OPC_SIGNED_COMPARE, 3'h7, 1'b1, 32'h1FF, 32'h1FF,
      1'b0, 1'b1, 1'b0);
    run(OPC_COMPARE_SUBTRACT, 3'h7, 1'b1, 32'h1FF, 32'h1FF,
      1'b0, 1'b0, 1'b0);
    run(OPC_SIGNED_COMPARE, 3'h7, 1'b0, 32'h5, 32'h1,
      1'b1, 1'b1, 1'b1);
    run(OPC_COMPARE_SUBTRACT, 3'h6, 1'b0, 32'h5, 32'h1,
      1'b1, 1'b1, 1'b1);
    run(OPC_SIGNED_COMPARE_EXT, 3'h7, 1'b0, 32'h5, 32'h1,
      1'b1, 1'b1, 1'b1);
    // Borrow check without result write, then the top word of a long compare
    run(OPC_SIGNED_COMPARE, 3'h2, 1'b0, 32'h8000_0000, 32'h1,
      1'b0, 1'b0, 1'b0);
    check({31'h0, c_flag}, 32'h1);
    run(OPC_SIGNED_COMPARE_EXT, 3'h6, 1'b0, 32'hFFFF_FFFF, 32'h0,
      1'b0, 1'b0, 1'b0);
    check({30'h0, c_flag, z_flag}, 32'h2);
    for (int i = 0; i < 40; i++) begin
      k = $urandom % 3;
      r = $urandom;
      w = $urandom;
      run(k == 0 ? OPC_SIGNED_COMPARE : k == 1 ? OPC_SIGNED_COMPARE_EXT :
        OPC_COMPARE_SUBTRACT, r[2:0], r[3], $urandom,
        r[4] ? w : w % 8, r[5], r[6], r[7]);
    end
    // Issue while busy is ignored
    wr(OFF_RF_BASE + 12'h00C, 32'h5);
    wr(OFF_INSTR, {OPC_SIGNED_COMPARE, 3'h7, 1'b0, CON_ALWAYS, 9'h001,
      9'h002});
    wr(OFF_INSTR, {OPC_COMPARE_SUBTRACT, 3'h1, 1'b1, CON_ALWAYS, 9'h003,
      9'h001});
    wait_done(k);
    retired_exp++;
    rd(OFF_RF_BASE + 12'h00C, v);
    check(v, 32'h5);
    rd(OFF_STATUS, v);
    check({31'h0, v[STAT_REFUSED]}, 32'h1);
    // Illegal words never start
    for (int i = 0; i < 3; i++) begin
      wr(OFF_STATUS, 32'h0000_000C);
      wr(OFF_INSTR, {i == 0 ? 6'h00 : OPC_SIGNED_COMPARE, 3'h7, 1'b0,
        i == 1 ? 4'h0 : CON_ALWAYS, i == 2 ? 9'h010 : 9'h001, 9'h002});
      #1 check({31'h0, busy}, 32'h0);
      rd(OFF_STATUS, v);
      check({31'h0, v[STAT_BAD]}, 32'h1);
    end
    // Only completed instructions are counted
    rd(OFF_RETIRED, v);
    check(v, 32'(retired_exp));
    print_verdict();
  end
endmodule

bind scalu_top scalu_monitor #(.W(W), .RF_DEPTH(RF_DEPTH)) u_mon (
  .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_en(wr_en),
  .rd_en(rd_en), .rdata(rdata), .busy(busy), .done(done),
  .z_flag(z_flag), .c_flag(c_flag));
`default_nettype wire
